// ---- bench/converter_interface_bench.sv ----
// Self-checking bench for converter_interface with a user-logic model.
// Assumes the checker and partner files are compiled before it.
`timescale 1ns/100ps
module converter_interface_bench;
    logic mclk, rst, ce, extSampleClk, dacHold;
    logic logicClkA, logicClkB, selLogicA, selLogicB, dacSampleClk;
    logic cfgSclk, cfgSdata, cfgLoad_n, dacFifoReady_ff, dacRetClk_ff;
    logic [1:0] selReq, adcDataClk_ff;
    logic [23:0] adcSample, adcBusEarly_ff, adcBusLate_ff;
    logic [15:0] dacDataA, dacDataB, dacOutA_ff, dacOutB_ff, a;
    logic [7:0] cfgWord_ff;
    logic [11:0] v1, v2;
    logic c, s;
    wire pllOn = cfgWord_ff[0];
    int n_fail = 0;
    int check_count = 0;
    int k;
    // Rows: converter, logic select, first sample, second sample
    logic [25:0] rows [4] = '{26'h0abc123, 26'h1fff000, 26'h2555aaa,
        26'h3001800};

    converter_interface i_dut (.mclk(mclk), .rst(rst), .ce(ce),
        .extSampleClk(extSampleClk), .logicClkA(logicClkA),
        .logicClkB(logicClkB), .selLogicA(selLogicA),
        .selLogicB(selLogicB), .adcSample(adcSample),
        .adcBusEarly_ff(adcBusEarly_ff), .adcBusLate_ff(adcBusLate_ff),
        .adcDataClk_ff(adcDataClk_ff), .dacSampleClk(dacSampleClk),
        .dacDataA(dacDataA), .dacDataB(dacDataB), .dacHold(dacHold),
        .dacFifoReady_ff(dacFifoReady_ff), .dacRetClk_ff(dacRetClk_ff),
        .dacOutA_ff(dacOutA_ff), .dacOutB_ff(dacOutB_ff),
        .cfgSclk(cfgSclk), .cfgSdata(cfgSdata), .cfgLoad_n(cfgLoad_n),
        .cfgWord_ff(cfgWord_ff));
    logic_partner i_partner (.mclk(mclk), .selReq(selReq),
        .dacRetClk_ff(dacRetClk_ff), .pllOn(pllOn),
        .logicClkA(logicClkA), .logicClkB(logicClkB),
        .selLogicA(selLogicA), .selLogicB(selLogicB),
        .dacSampleClk(dacSampleClk), .dacDataA(dacDataA),
        .dacDataB(dacDataB), .cfgSclk(cfgSclk), .cfgSdata(cfgSdata),
        .cfgLoad_n(cfgLoad_n));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // External sample clock, unrelated in phase to mclk
    initial begin
        extSampleClk = 1'b0;
        #7;
        forever #62.5 extSampleClk = ~extSampleClk;
    end
    initial begin
        #100000;
        n_fail++;
        complete_run;
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wait_dclk(input int n, input logic v);
        for (k = 0; k < 100 && adcDataClk_ff[n] !== v; k++) @(negedge mclk);
        check(adcDataClk_ff[n], v);
    endtask
    task automatic load_mode(input logic [7:0] w);
        i_partner.send_cfg(w);
        repeat (60) @(negedge mclk);
        check(cfgWord_ff, w);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        dacHold = 1'b0;
        selReq = 2'b00;
        adcSample = 24'h000000;
        repeat (3) @(negedge mclk);
        check({cfgWord_ff, dacOutA_ff}, 24'h000000);
        rst = 1'b0;
        // Data taken after a select change is thrown away first
        for (int r = 0; r < 4; r++) begin
            {c, s, v1, v2} = rows[r];
            selReq[c] = s;
            adcSample[12*c +: 12] = v1;
            wait_dclk(c, 1'b0);
            wait_dclk(c, 1'b1);
            wait_dclk(c, 1'b0);
            adcSample[12*c +: 12] = v2;
            wait_dclk(c, 1'b1);
            check(adcBusEarly_ff[12*c +: 12], v1);
            check(adcBusLate_ff[12*c +: 12], v2);
        end
        check(dacOutB_ff, dacOutA_ff + 16'h0001);
        a = dacOutA_ff;
        load_mode(8'h02);
        check(dacOutA_ff, dacOutB_ff + 16'h0001);
        check(dacOutA_ff == a, 1'b0);
        load_mode(8'h01);
        check(dacRetClk_ff, 1'b0);
        check(dacOutB_ff, dacOutA_ff + 16'h0001);
        // Clock enable low freezes everything, buffer and outputs too
        ce = 1'b0;
        a = dacOutA_ff;
        repeat (40) @(negedge mclk);
        check(dacOutA_ff, a);
        check(dacOutB_ff, a + 16'h0001);
        ce = 1'b1;
        load_mode(8'h00);
        // Stall the drain until the buffer refuses, then let it go
        dacHold = 1'b1;
        for (k = 0; k < 600 && dacFifoReady_ff !== 1'b0; k++) @(negedge mclk);
        check(dacFifoReady_ff, 1'b0);
        dacHold = 1'b0;
        for (k = 0; k < 600 && dacFifoReady_ff !== 1'b1; k++) @(negedge mclk);
        check(dacFifoReady_ff, 1'b1);
        check(dacOutB_ff, dacOutA_ff + 16'h0001);
        // Reset again in mid-run: outputs clear, then capture restarts
        rst = 1'b1;
        @(negedge mclk);
        check({cfgWord_ff, dacOutA_ff}, 24'h000000);
        check({adcDataClk_ff, dacOutB_ff}, 24'h000000);
        rst = 1'b0;
        wait_dclk(0, 1'b1);
        complete_run;
    end
endmodule

// ---- bench/converter_interface_chk.sv ----
// Port checker for converter_interface.
// Assumes it is bound to the block and sees its ports only.
`timescale 1ns/100ps
module converter_interface_chk (
    input wire mclk,
    input wire rst,
    input wire dacSampleClk,
    input wire dacHold,
    input wire cfgLoad_n,
    input wire [23:0] adcBusEarly_ff,
    input wire [23:0] adcBusLate_ff,
    input wire [1:0] adcDataClk_ff,
    input wire dacFifoReady_ff,
    input wire dacRetClk_ff,
    input wire [15:0] dacOutA_ff,
    input wire [15:0] dacOutB_ff,
    input wire [7:0] cfgWord_ff
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Output clock pin steady long enough to pass the pin filter
    sequence s_dac_steady;
        (!cfgWord_ff[0] && $stable(dacSampleClk)) [*7];
    endsequence
    a_reset_clear: assert property (disable iff (1'b0)
        rst |-> cfgWord_ff == 8'h00 && adcDataClk_ff == 2'b00)
        else $error("outputs not cleared by reset");
    a_bus_a_paced: assert property (
        $changed({adcBusEarly_ff[11:0], adcBusLate_ff[11:0]})
        |-> $rose(adcDataClk_ff[0]))
        else $error("bus A moved off its data clock");
    a_bus_b_paced: assert property (
        $changed({adcBusEarly_ff[23:12], adcBusLate_ff[23:12]})
        |-> $rose(adcDataClk_ff[1]))
        else $error("bus B moved off its data clock");
    a_ret_follows: assert property (
        s_dac_steady |-> dacRetClk_ff == dacSampleClk)
        else $error("returned clock lost the sample clock");
    a_pll_quiet: assert property (
        cfgWord_ff[0] && $past(cfgWord_ff[0]) |-> !dacRetClk_ff)
        else $error("returned clock runs with loop enabled");
    // With the PLL off, both channels move only around a returned clock high phase
    a_dac_paired: assert property (
        ($changed(dacOutA_ff) || $changed(dacOutB_ff)) && !cfgWord_ff[0]
        && cfgWord_ff == $past(cfgWord_ff, 2) |-> ##[0:1] dacRetClk_ff)
        else $error("channel update without returned clock");
    a_cfg_on_load: assert property (
        $changed(cfgWord_ff) |-> cfgLoad_n)
        else $error("mode word changed while loading");
    a_fill_on_hold: assert property (
        $fell(dacFifoReady_ff) |-> $past(dacHold))
        else $error("buffer filled without a stall");
endmodule

bind converter_interface converter_interface_chk i_chk (.mclk(mclk),
    .rst(rst), .dacSampleClk(dacSampleClk), .dacHold(dacHold),
    .cfgLoad_n(cfgLoad_n), .adcBusEarly_ff(adcBusEarly_ff),
    .adcBusLate_ff(adcBusLate_ff), .adcDataClk_ff(adcDataClk_ff),
    .dacFifoReady_ff(dacFifoReady_ff), .dacRetClk_ff(dacRetClk_ff),
    .dacOutA_ff(dacOutA_ff), .dacOutB_ff(dacOutB_ff),
    .cfgWord_ff(cfgWord_ff));

// ---- bench/logic_partner.sv ----
// Model of the user logic: sample clocks, selects, words, mode loads.
// Assumes mclk runs free; every output moves on falling mclk.
`timescale 1ns/100ps
module logic_partner (
    input wire mclk,
    input wire [1:0] selReq,
    input wire dacRetClk_ff,
    input wire pllOn,
    output logic logicClkA,
    output logic logicClkB,
    output logic selLogicA,
    output logic selLogicB,
    output logic dacSampleClk,
    output logic [15:0] dacDataA,
    output logic [15:0] dacDataB,
    output logic cfgSclk,
    output logic cfgSdata,
    output logic cfgLoad_n
);
    int tick = 0;
    logic prevRet = 1'b0;
    logic prevDac = 1'b0;
    initial begin
        {logicClkA, logicClkB, selLogicA, selLogicB, dacSampleClk} = 5'h00;
        {dacDataA, dacDataB} = {16'h0000, 16'h0001};
        {cfgSclk, cfgSdata, cfgLoad_n} = 3'h1;
    end
    // Clocks divided from mclk; each converter gets its own rate
    always @(negedge mclk) begin
        tick <= tick + 1;
        if (tick % 4 == 0) logicClkA <= ~logicClkA;
        if (tick % 6 == 0) logicClkB <= ~logicClkB;
        if (tick % 8 == 0) dacSampleClk <= ~dacSampleClk;
        selLogicA <= selReq[0];
        selLogicB <= selReq[1];
        prevRet <= dacRetClk_ff;
        prevDac <= dacSampleClk;
        // Launch after the falling edge of whichever clock times data
        if (pllOn ? (prevDac && !dacSampleClk)
                : (prevRet && !dacRetClk_ff)) begin
            dacDataA <= dacDataA + 16'h0001;
            dacDataB <= dacDataA + 16'h0002;
        end
    end
    // Serial mode load, MSB first, slow enough for the pin filter
    task automatic send_cfg(input logic [7:0] w);
        cfgLoad_n <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            repeat (5) @(negedge mclk);
            cfgSdata <= w[i];
            cfgSclk <= 1'b0;
            repeat (5) @(negedge mclk);
            cfgSclk <= 1'b1;
        end
        repeat (5) @(negedge mclk);
        cfgSclk <= 1'b0;
        repeat (5) @(negedge mclk);
        cfgLoad_n <= 1'b1;
    endtask
endmodule

// ---- hdl/converter_interface.v ----
// Converter side of the sample-clock and data interface: two input
// converters with demultiplexed outputs and a two-channel output converter.
// Assumes every pin input is asynchronous to mclk and much slower than it;
// sample words on adcSample are steady around the sample clock edges.
`timescale 1ns/100ps

`include "converter_map.vh"

// What this block does
// - Two 12-bit buses, half-rate data clock
// - Each input converter has own clock
// - Both output channels share one clock
// - PLL off: returned clock times output data
// - Reset gives plain two-channel mode; serial config
module converter_interface (
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire extSampleClk,
    input wire logicClkA,
    input wire logicClkB,
    input wire selLogicA,
    input wire selLogicB,
    input wire [23:0] adcSample,
    output reg [23:0] adcBusEarly_ff,
    output reg [23:0] adcBusLate_ff,
    output reg [1:0] adcDataClk_ff,
    input wire dacSampleClk,
    input wire [15:0] dacDataA,
    input wire [15:0] dacDataB,
    input wire dacHold,
    output reg dacFifoReady_ff,
    output reg dacRetClk_ff,
    output reg [15:0] dacOutA_ff,
    output reg [15:0] dacOutB_ff,
    input wire cfgSclk,
    input wire cfgSdata,
    input wire cfgLoad_n,
    output reg [7:0] cfgWord_ff
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    wire [`PIN_COUNT-1:0] pinRaw; // Asynchronous pins gathered
    reg [`PIN_COUNT-1:0] syncOne_ff; // First stage, read by stage two only
    reg [`PIN_COUNT-1:0] syncTwo_ff; // Second stage
    reg [`PIN_COUNT-1:0] syncThree_ff; // Third stage
    reg [`PIN_COUNT-1:0] pinLvl_ff; // Level accepted once stages agree
    reg [`PIN_COUNT-1:0] pinRise; // One-cycle rising strobes

    assign pinRaw = {cfgLoad_n, cfgSdata, cfgSclk, dacSampleClk,
                     selLogicB, selLogicA, logicClkB, logicClkA,
                     extSampleClk};

    genvar p;
    generate
        for (p = 0; p < `PIN_COUNT; p = p + 1) begin : pinSync
            // Reset to the pin's idle level, so release makes no false edge
            localparam IDLE_LVL = (p == `PIN_CFG_LOAD_N) ? 1'b1 : 1'b0;

            // Three stages; a change counts only when two and three agree
            always @(posedge mclk or posedge rst) begin
                if (rst) begin
                    syncOne_ff[p] <= IDLE_LVL;
                    syncTwo_ff[p] <= IDLE_LVL;
                    syncThree_ff[p] <= IDLE_LVL;
                    pinLvl_ff[p] <= IDLE_LVL;
                end else if (ce) begin
                    syncOne_ff[p] <= pinRaw[p];
                    syncTwo_ff[p] <= syncOne_ff[p];
                    syncThree_ff[p] <= syncTwo_ff[p];
                    if (syncTwo_ff[p] == syncThree_ff[p]) begin
                        pinLvl_ff[p] <= syncThree_ff[p];
                    end
                end
            end

            // Rising change, seen the cycle the level is accepted
            always @* begin
                pinRise[p] = syncTwo_ff[p] & syncThree_ff[p] & ~pinLvl_ff[p];
            end
        end
    endgenerate

    // ****************************************************************
    // Input converters, one per channel
    // ****************************************************************
    reg [1:0] selClkPrev_ff; // Previous selected sample clock level
    reg [1:0] phase_ff; // Which half of the sample pair is next
    reg [23:0] holdEarly_ff; // Earlier sample waiting for its partner
    wire [1:0] selClk; // Selected sample clock level per converter
    wire [1:0] selLvl; // Filtered select levels

    assign selLvl = {pinLvl_ff[`PIN_SEL_B], pinLvl_ff[`PIN_SEL_A]};

    genvar k;
    generate
        for (k = 0; k < 2; k = k + 1) begin : adcChan
            // Each converter picks its own source, so rates may differ
            // Logic keeps the select steady while sampling
            assign selClk[k] = selLvl[k] ?
                pinLvl_ff[`PIN_LOGIC_CLK_A + k] :
                pinLvl_ff[`PIN_EXT_CLK];

            // Sample pairing and the half-rate data clock
            always @(posedge mclk or posedge rst) begin
                if (rst) begin
                    selClkPrev_ff[k] <= 1'b0;
                    phase_ff[k] <= 1'b0;
                    holdEarly_ff[k*12 +: 12] <= 12'h000;
                    adcBusEarly_ff[k*12 +: 12] <= 12'h000;
                    adcBusLate_ff[k*12 +: 12] <= 12'h000;
                    adcDataClk_ff[k] <= 1'b0;
                end else if (ce) begin
                    selClkPrev_ff[k] <= selClk[k];
                    if (selClk[k] & ~selClkPrev_ff[k]) begin
                        phase_ff[k] <= ~phase_ff[k];
                        // Data clock toggles per sample: half the rate;
                        // low after the first sample, high with the buses
                        adcDataClk_ff[k] <= phase_ff[k];
                        if (!phase_ff[k]) begin
                            // First of the pair waits for its partner
                            holdEarly_ff[k*12 +: 12] <=
                                adcSample[k*12 +: 12];
                        end else begin
                            // Both buses change with the data clock rise
                            adcBusEarly_ff[k*12 +: 12] <=
                                holdEarly_ff[k*12 +: 12];
                            adcBusLate_ff[k*12 +: 12] <=
                                adcSample[k*12 +: 12];
                        end
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Serial configuration of the output converter
    // ****************************************************************
    reg [7:0] cfgShift_ff; // Bits shifted in while load is low
    wire cfgLoadRise; // Load released: commit the word

    assign cfgLoadRise = pinRise[`PIN_CFG_LOAD_N];

    // Reset leaves a plain two-channel converter with the PLL off
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfgShift_ff <= `CFG_RESET;
            cfgWord_ff <= `CFG_RESET;
        end else if (ce) begin
            if (pinRise[`PIN_CFG_SCLK] & ~pinLvl_ff[`PIN_CFG_LOAD_N]) begin
                // Most significant bit first
                cfgShift_ff <= {cfgShift_ff[6:0],
                                pinLvl_ff[`PIN_CFG_SDATA]};
            end
            if (cfgLoadRise) begin
                cfgWord_ff <= cfgShift_ff;
            end
        end
    end

    // ****************************************************************
    // Output converter: shared sample clock, returned clock, buffer
    // ****************************************************************
    wire dacEdge; // Rising edge of the single shared sample clock
    wire pllOn; // Internal PLL enabled by configuration
    wire fifoInReady;
    wire fifoOutValid;
    wire [31:0] fifoOutData;
    wire drainReady; // Core takes a word on each sample edge unless held

    assign dacEdge = pinRise[`PIN_DAC_CLK];
    assign pllOn = cfgWord_ff[`CFG_PLL_BIT];
    assign drainReady = dacEdge & ~dacHold;

    // Words enter on the sample edge; with the PLL off that edge is also
    // the returned clock edge, so both timings coincide here
    sample_fifo #(
        .WIDTH(32),
        .DEPTH(`DAC_FIFO_DEPTH),
        .AW(4)
    ) dacFifo (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .inValid(dacEdge),
        .inReady(fifoInReady),
        .inData({dacDataB, dacDataA}),
        .outValid(fifoOutValid),
        .outReady(drainReady),
        .outData(fifoOutData)
    );

    // Returned clock only while the PLL is off; held low otherwise
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            dacRetClk_ff <= 1'b0;
            dacFifoReady_ff <= 1'b0;
            dacOutA_ff <= 16'h0000;
            dacOutB_ff <= 16'h0000;
        end else if (ce) begin
            dacRetClk_ff <= pinLvl_ff[`PIN_DAC_CLK] & ~pllOn;
            dacFifoReady_ff <= fifoInReady;
            // Both channels update together on the one clock
            if (drainReady & fifoOutValid) begin
                if (cfgWord_ff[`CFG_SWAP_BIT]) begin
                    dacOutA_ff <= fifoOutData[31:16];
                    dacOutB_ff <= fifoOutData[15:0];
                end else begin
                    dacOutA_ff <= fifoOutData[15:0];
                    dacOutB_ff <= fifoOutData[31:16];
                end
            end
        end
    end

endmodule

// ---- hdl/converter_map.vh ----
// Constants for the converter clock and data interface.
// Assumes inclusion by bare name from design files under hdl/.
`ifndef CONVERTER_MAP_VH
`define CONVERTER_MAP_VH

// ****************************************************************
// Widths
// ****************************************************************
`define ADC_WIDTH 12
`define DAC_WIDTH 16
`define CFG_WIDTH 8

// ****************************************************************
// Pin index positions inside the synchroniser vector
// ****************************************************************
`define PIN_EXT_CLK 0
`define PIN_LOGIC_CLK_A 1
`define PIN_LOGIC_CLK_B 2
`define PIN_SEL_A 3
`define PIN_SEL_B 4
`define PIN_DAC_CLK 5
`define PIN_CFG_SCLK 6
`define PIN_CFG_SDATA 7
`define PIN_CFG_LOAD_N 8
`define PIN_COUNT 9

// ****************************************************************
// Output converter mode word: field positions and reset value
// ****************************************************************
`define CFG_PLL_BIT 0
`define CFG_SWAP_BIT 1
`define CFG_RESET 8'h00

// ****************************************************************
// Buffering
// ****************************************************************
`define DAC_FIFO_DEPTH 16

`endif

// ---- hdl/sample_fifo.v ----
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock, an active-high asynchronous reset and a clock enable.
`timescale 1ns/100ps

module sample_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);

    // ****************************************************************
    // Storage and pointers
    // ****************************************************************
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // Word store
    reg [AW:0] wrPtr_ff; // Write pointer, extra bit tells full from empty
    reg [AW:0] rdPtr_ff; // Read pointer
    wire isEmpty;
    wire isFull;
    wire doWrite;
    wire doRead;

    assign isEmpty = (wrPtr_ff == rdPtr_ff);
    assign isFull = (wrPtr_ff[AW] != rdPtr_ff[AW]) &&
                    (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]);
    assign inReady = ~isFull;
    assign outValid = ~isEmpty;
    assign outData = mem[rdPtr_ff[AW-1:0]];
    // Frozen clock enable blocks both sides so pointers cannot drift
    assign doWrite = ce & inValid & ~isFull;
    assign doRead = ce & outReady & ~isEmpty;

    // ****************************************************************
    // Store write; memory has no reset, contents are don't-care
    // ****************************************************************
    always @(posedge mclk) begin
        if (doWrite) begin
            mem[wrPtr_ff[AW-1:0]] <= inData;
        end
    end

    // Pointer update
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            wrPtr_ff <= {(AW+1){1'b0}};
            rdPtr_ff <= {(AW+1){1'b0}};
        end else begin
            if (doWrite) begin
                wrPtr_ff <= wrPtr_ff + 1'b1;
            end
            if (doRead) begin
                rdPtr_ff <= rdPtr_ff + 1'b1;
            end
        end
    end

endmodule
